// File: pkg/l2c_pkg.sv
package l2c_pkg;
    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    localparam int IDX_W    = 12;  // 4K lines
    localparam int TAG_W    = 13;  // stored tag width
    localparam int TAG_HI   = 28;
    localparam int TAG_LO   = 16;
    localparam int IDX_HI   = 15;
    localparam int IDX_LO   = 4;
    localparam int LW_HI    = 3;
    localparam int LW_LO    = 2;
    localparam int SPACE_HI = 31;  // bits that must be zero to cache
    localparam int SPACE_LO = 29;
    localparam int BEATS    = 4;   // longwords per line
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    localparam logic [7:0]  CSR_OFS    = 8'h00;
    localparam logic [7:0]  STAT_OFS   = 8'h04;
    localparam int          EXT_EN_BIT = 26;
    localparam int          TPERR_BIT  = 0;
    localparam int          DPERR_BIT  = 1;
    localparam logic        EXT_EN_RST = 1'b0;
    localparam logic [31:0] RDATA_RST  = 32'h0000_0000;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [TAG_W-1:0] tag;     // address bits 28:16
        logic             dirty;
        logic             shared;
        logic             par;     // even parity over tag, dirty, shared
    } tag_entry_t;

    typedef enum logic [2:0] {
        S_IDLE, S_WT, S_INV, S_VICT, S_FILL, S_SUPPLY
    } ctl_state_t;
endpackage : l2c_pkg

// File: pkg/tag_if.sv
`timescale 1ns/1ps
interface tag_if;
    import l2c_pkg::*;
    logic [TAG_W-1:0] want;    // tag of the address looked up
    tag_entry_t       ent;     // entry read from the tag store
    logic             vld;     // entry holds a line
    logic             hit;
    logic             perr;
    logic [TAG_W-1:0] wtag;    // fields to write back
    logic             wdirty;
    logic             wshared;
    tag_entry_t       went;    // write entry with fresh parity
    modport ctl (output want, ent, vld, wtag, wdirty, wshared,
                 input  hit, perr, went);
    modport chk (input  want, ent, vld, wtag, wdirty, wshared,
                 output hit, perr, went);
endinterface : tag_if

// File: rtl/tag_check.sv
`timescale 1ns/1ps
module tag_check
    import l2c_pkg::*;
(
    tag_if.chk t
);
    // ---------------------------------------------------------------
    // parity check, compare and parity generation
    // ---------------------------------------------------------------
    logic calc_par;  // parity of the stored fields

    assign calc_par = ^{t.ent.tag, t.ent.dirty, t.ent.shared};
    // a bad entry never hits, so it is refetched
    assign t.perr   = t.vld && (calc_par != t.ent.par);
    assign t.hit    = t.vld && !t.perr && (t.ent.tag == t.want);
    // every tag write carries newly computed parity
    assign t.went   = '{tag: t.wtag, dirty: t.wdirty, shared: t.wshared,
                        par: ^{t.wtag, t.wdirty, t.wshared}};
endmodule : tag_check

// File: rtl/snoopy_l2_cache_controller.sv
// Summary of operation
// - level-1: 1 KB, two-way, write-through, quadword
// - I/O-space references are never cached
// - level-1 byte and tag parity checked internally
// - invalidate level-1 on eviction or snoop update
// - level-2: 64 KB direct-mapped write-back, 4K lines
// - entry: 128 data, 15 tag, 17 parity bits
// - longword access; line moves as four longwords
// - every level-1 miss makes a level-2 cycle
// - data parity by processor or bus side
// - take pin bus by DMA before data store
// - cache only lowest 512 MB memory
// - index 15:4, longword 3:2, tag 28:16
// - allocation writes new address into tag
// - data-store write updates dirty flag
// - snoop hits and shared write hits update the shared flag
// - tag parity generated on write, checked on read
// - only this controller touches the tag store
// - control bit 26 enables external cache
// - single internal entry serves before enable
// - snooped read hit: share, respond, supply dirty
// - snooped write hit: share, respond, clear dirty
// - shared write hit: masked write-through, resample shared
// - dirty miss: invalidate, write back, then fill
`timescale 1ns/1ps
module snoopy_l2_cache_controller
    import l2c_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    // processor side
    input  wire logic        cpu_req,        // level-1 miss cycle
    input  wire logic        cpu_we,
    input  wire logic [31:0] cpu_addr,
    output logic             cpu_done,
    output logic             cpu_retry,
    output logic             l1_inval,
    output logic             dma_req,
    input  wire logic        dma_grant,
    // data store
    output logic [13:0]      ds_addr,
    output logic             ds_we,
    output logic [31:0]      ds_wdata,
    output logic [3:0]       ds_wpar,
    input  wire logic [31:0] ds_rdata,
    input  wire logic [3:0]  ds_rpar,
    // system bus, own transfers
    output logic             bus_rd_req,
    output logic             bus_vw_req,
    output logic             bus_wt_req,
    output logic [31:0]      bus_addr,
    output logic [31:0]      bus_wdata,
    output logic             bus_wvalid,
    input  wire logic [31:0] bus_rdata,
    input  wire logic        bus_ack,
    input  wire logic        shared_response_in,
    // system bus, snooping
    input  wire logic        snoop_valid,
    input  wire logic        snoop_wr,
    input  wire logic [31:0] snoop_addr,
    output logic             snoop_ack,
    output logic             shared_response_out,
    output logic             snoop_supply,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata
);
    localparam int LINES = 1 << IDX_W;  // 4K direct-mapped lines

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    ctl_state_t       state_r, state_nxt;
    logic [31:0]      addr_r;            // address of the running op
    logic             fsnoop_r;          // fill carries snooped data
    logic             vdirty_r;          // victim needs write-back
    logic [1:0]       beat_r;            // longword counter
    logic             wv_r;              // outgoing longword held
    logic             ext_en_r;          // external cache on
    logic             tperr_r, dperr_r;  // sticky error flags
    logic             ds_we_r;
    logic [1:0]       wbeat_r;           // longword being written
    logic [31:0]      ds_wdata_r, bus_wdata_r, rdata_r;
    logic [3:0]       ds_wpar_r;
    logic             shared_r;          // shared response pulse
    tag_entry_t       tag_mem [0:LINES-1]; // tag word and parity per line
    logic [LINES-1:0] valid_r;
    tag_entry_t       se_ent_r;          // power-up single entry
    logic [IDX_W-1:0] se_idx_r;
    logic             se_vld_r;
    // combinational
    logic [31:0]      lk_addr;
    logic [IDX_W-1:0] idx;
    logic             cacheable, tag_wr, tperr_set, dperr_set, last;
    logic             csr_wr, stat_wr;
    tag_if            tif ();

    tag_check u_chk (
        .t (tif.chk)
    );

    // even parity per byte, same sense as the processor's own stores
    function automatic logic [3:0] byte_par(input logic [31:0] d);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 0; i < 4; i++) begin
            p[i] = ^d[8*i +: 8];
        end
        return p;
    endfunction : byte_par

    // ---------------------------------------------------------------
    // lookup
    // ---------------------------------------------------------------
    // idle probes the new request, else the latched one
    assign lk_addr  = (state_r != S_IDLE) ? addr_r
                    : (snoop_valid ? snoop_addr : cpu_addr);
    assign idx      = lk_addr[IDX_HI:IDX_LO];
    assign tif.want = lk_addr[TAG_HI:TAG_LO];
    // internal entry stands in until software enables
    assign tif.ent  = ext_en_r ? tag_mem[idx] : se_ent_r;
    assign tif.vld  = ext_en_r ? valid_r[idx]
                               : (se_vld_r && (se_idx_r == idx));
    // memory space below 512 MB only; I/O never allocates
    assign cacheable = (cpu_addr[SPACE_HI:SPACE_LO] == 3'h0);
    assign last      = dma_grant && (beat_r == 2'(BEATS-1));

    // ---------------------------------------------------------------
    // sequencing
    // ---------------------------------------------------------------
    always_comb begin
        state_nxt   = state_r;
        cpu_done    = 1'b0;
        cpu_retry   = 1'b0;
        snoop_ack   = 1'b0;
        tag_wr      = 1'b0;
        tif.wtag    = tif.ent.tag;
        tif.wdirty  = tif.ent.dirty;
        tif.wshared = tif.ent.shared;
        tperr_set   = 1'b0;
        unique case (state_r)
            S_IDLE: begin
                if (snoop_valid) begin
                    snoop_ack = 1'b1;
                    tperr_set = tif.perr;
                    if (tif.hit) begin
                        tag_wr      = 1'b1;
                        tif.wshared = 1'b1;
                        if (snoop_wr) begin
                            tif.wdirty = 1'b0;
                            state_nxt  = S_INV;
                        end else if (tif.ent.dirty) begin
                            state_nxt = S_SUPPLY;
                        end
                    end
                end else if (cpu_req && !ds_we_r) begin  // fill tail owns store
                    tperr_set = tif.perr && cacheable;
                    if (!cacheable) begin
                        cpu_done = 1'b1;
                    end else if (tif.hit) begin
                        if (cpu_we) begin
                            tag_wr     = 1'b1;
                            tif.wdirty = 1'b1;
                        end
                        if (cpu_we && tif.ent.shared) begin
                            state_nxt = S_WT;
                        end else begin
                            cpu_done = 1'b1;
                        end
                    end else begin
                        // miss: retry the processor and refill
                        cpu_retry = 1'b1;
                        state_nxt = tif.vld ? S_INV : S_FILL;
                    end
                end
            end
            S_WT: begin
                if (bus_ack) begin
                    tag_wr      = 1'b1;
                    tif.wshared = shared_response_in;
                    cpu_done    = 1'b1;
                    state_nxt   = S_IDLE;
                end
            end
            S_INV: begin
                // one invalidate cycle, then move data
                state_nxt = (vdirty_r && !fsnoop_r) ? S_VICT : S_FILL;
            end
            S_VICT: begin
                if (wv_r && bus_ack && last) begin
                    state_nxt = S_FILL;
                end
            end
            S_FILL: begin
                if (bus_ack && last) begin
                    state_nxt = S_IDLE;
                    if (!fsnoop_r) begin
                        tag_wr      = 1'b1;
                        tif.wtag    = addr_r[TAG_HI:TAG_LO];
                        tif.wdirty  = 1'b0;
                        tif.wshared = shared_response_in;
                    end
                end
            end
            S_SUPPLY: begin
                if (wv_r && bus_ack && last) begin
                    state_nxt = S_IDLE;
                end
            end
        endcase
    end

    // state and latched operation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= S_IDLE;
            addr_r   <= 32'h0000_0000;
            fsnoop_r <= 1'b0;
            vdirty_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == S_IDLE && state_nxt != S_IDLE) begin
                addr_r   <= lk_addr;
                fsnoop_r <= snoop_valid;
                // parity-bad victims count as clean
                vdirty_r <= tif.vld && tif.ent.dirty && !tif.perr;
            end
        end
    end

    // ---------------------------------------------------------------
    // tag store: written only here
    // ---------------------------------------------------------------
    // no reset on the array; valid bits alone are cleared
    always_ff @(posedge clk) begin
        if (tag_wr && ext_en_r) begin
            tag_mem[idx] <= tif.went;
        end
    end

    // valid bits and the internal entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_r  <= '0;
            se_ent_r <= '0;
            se_idx_r <= '0;
            se_vld_r <= 1'b0;
        end else if (tag_wr && ext_en_r) begin
            valid_r[idx] <= 1'b1;
        end else if (tag_wr) begin
            se_ent_r <= tif.went;
            se_idx_r <= idx;
            se_vld_r <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // longword transfers under DMA ownership
    // ---------------------------------------------------------------
    // fill beat advances only while the pin bus is ours; write-out beat on the ack of the held longword
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            beat_r      <= 2'h0;
            wv_r        <= 1'b0;
            bus_wdata_r <= 32'h0000_0000;
        end else if (state_r == S_VICT || state_r == S_SUPPLY) begin
            if (dma_grant && !wv_r) begin
                bus_wdata_r <= ds_rdata;
                wv_r        <= 1'b1;
            end else if (wv_r && bus_ack) begin
                wv_r   <= 1'b0;
                beat_r <= beat_r + 2'h1;
            end
        end else if (state_r == S_FILL && dma_grant && bus_ack) begin
            beat_r <= beat_r + 2'h1;
        end
    end

    // fill writes carry parity made on the bus side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ds_we_r    <= 1'b0;
            wbeat_r    <= 2'h0;
            ds_wdata_r <= 32'h0000_0000;
            ds_wpar_r  <= 4'h0;
        end else begin
            ds_we_r <= (state_r == S_FILL) && dma_grant && bus_ack;
            if (state_r == S_FILL && dma_grant && bus_ack) begin
                wbeat_r    <= beat_r;
                ds_wdata_r <= bus_rdata;
                ds_wpar_r  <= byte_par(bus_rdata);
            end
        end
    end

    // outgoing longwords are checked on the bus side
    assign dperr_set = (state_r == S_VICT || state_r == S_SUPPLY)
                    && dma_grant && !wv_r && (byte_par(ds_rdata) != ds_rpar);

    // ---------------------------------------------------------------
    // pins
    // ---------------------------------------------------------------
    assign ds_addr    = ds_we_r ? {addr_r[IDX_HI:IDX_LO], wbeat_r}
                      : (state_r == S_IDLE) ? {idx, lk_addr[LW_HI:LW_LO]}
                      : {idx, beat_r};
    assign ds_we      = ds_we_r;
    assign ds_wdata   = ds_wdata_r;
    assign ds_wpar    = ds_wpar_r;
    // hold the pin bus through the last write behind the fill
    assign dma_req    = (state_r == S_VICT) || (state_r == S_FILL)
                     || (state_r == S_SUPPLY) || ds_we_r;
    assign l1_inval   = (state_r == S_INV);
    assign bus_rd_req = (state_r == S_FILL) && !fsnoop_r && dma_grant;
    assign bus_vw_req = (state_r == S_VICT);
    assign bus_wt_req = (state_r == S_WT);
    assign bus_addr   = (state_r == S_VICT)
                      ? {3'h0, tif.ent.tag, addr_r[IDX_HI:IDX_LO], 4'h0}
                      : {addr_r[31:4], 4'h0};
    assign bus_wdata  = bus_wdata_r;
    assign bus_wvalid = wv_r;
    assign snoop_supply = (state_r == S_SUPPLY);

    // shared response one cycle after a snoop hit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shared_r <= 1'b0;
        end else begin
            shared_r <= snoop_ack && tif.hit;
        end
    end
    assign shared_response_out = shared_r;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    assign csr_wr  = reg_wr && (reg_addr == CSR_OFS);
    assign stat_wr = reg_wr && (reg_addr == STAT_OFS);

    // enable bit of the interface control/status register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_en_r <= EXT_EN_RST;
        end else if (csr_wr) begin
            ext_en_r <= reg_wdata[EXT_EN_BIT];
        end
    end

    // sticky errors, write one to clear; a new event wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tperr_r <= 1'b0;
            dperr_r <= 1'b0;
        end else begin
            tperr_r <= tperr_set
                    || (tperr_r && !(stat_wr && reg_wdata[TPERR_BIT]));
            dperr_r <= dperr_set
                    || (dperr_r && !(stat_wr && reg_wdata[DPERR_BIT]));
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= RDATA_RST;
        end else begin
            rdata_r <= RDATA_RST;
            if (reg_rd && reg_addr == CSR_OFS) begin
                rdata_r[EXT_EN_BIT] <= ext_en_r;
            end else if (reg_rd && reg_addr == STAT_OFS) begin
                rdata_r[TPERR_BIT] <= tperr_r;
                rdata_r[DPERR_BIT] <= dperr_r;
            end
        end
    end
    assign reg_rdata = rdata_r;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence dirty_miss_s;
        state_r == S_IDLE && cpu_req && !ds_we_r && !snoop_valid && cacheable
            && !tif.hit && tif.vld && tif.ent.dirty && !tif.perr;
    endsequence
    sequence inv_then_vict_s;
        l1_inval ##1 (bus_vw_req && dma_req);
    endsequence

    io_bypass_a: assert property (
        (state_r == S_IDLE && cpu_req && !ds_we_r && !snoop_valid && !cacheable)
            |-> cpu_done && !cpu_retry ##1 !ds_we && !dma_req)
        else $error("uncached reference touched the cache");
    victim_order_a: assert property (
        dirty_miss_s |-> cpu_retry ##1 inv_then_vict_s)
        else $error("dirty miss did not invalidate then write back");
    dma_own_a: assert property (
        (state_r == S_FILL && bus_ack && !dma_grant) |=> !ds_we)
        else $error("data store written without pin bus");
    hit_decode_a: assert property (
        (cpu_done && state_r == S_IDLE && cacheable)
            |-> ds_addr == {cpu_addr[IDX_HI:IDX_LO], cpu_addr[LW_HI:LW_LO]})
        else $error("data store address not from 15:2");
    ext_enable_a: assert property (
        csr_wr |=> ext_en_r == $past(reg_wdata[EXT_EN_BIT]))
        else $error("enable bit did not follow the write");
    snoop_share_a: assert property (
        (snoop_ack && tif.hit) |=> shared_response_out
            ##1 (shared_response_out == $past(snoop_ack && tif.hit)))
        else $error("shared response not pulsed on snoop hit");
    snoop_inval_a: assert property (
        (snoop_ack && tif.hit && snoop_wr) |=> l1_inval ##1 !l1_inval)
        else $error("snooped update did not invalidate level-1");
    shared_wt_a: assert property (
        (state_r == S_IDLE && !snoop_valid && cpu_req && !ds_we_r && cpu_we
            && cacheable && tif.hit && tif.ent.shared)
            |-> !cpu_done ##1 bus_wt_req)
        else $error("shared write hit without write-through");
    tag_perr_a: assert property (
        (state_r == S_IDLE && !snoop_valid && cpu_req && !ds_we_r && cacheable
            && tif.perr) |-> cpu_retry ##1 tperr_r)
        else $error("tag parity error not a flagged miss");
endmodule : snoopy_l2_cache_controller

// File: testbench/bus_side_model.sv
`timescale 1ns/1ps
module bus_side_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        dma_req,
    output logic             dma_grant,
    input  wire logic [13:0] ds_addr,
    input  wire logic        ds_we,
    input  wire logic [31:0] ds_wdata,
    input  wire logic [3:0]  ds_wpar,
    output logic [31:0]      ds_rdata,
    output logic [3:0]       ds_rpar,
    input  wire logic        bus_rd_req,
    input  wire logic        bus_vw_req,
    input  wire logic        bus_wt_req,
    input  wire logic        bus_wvalid,
    input  wire logic        snoop_supply,
    output logic [31:0]      bus_rdata,
    output logic             bus_ack,
    output logic             shared_response_in
);
    logic [35:0] store [0:16383];  // longword store with byte parity
    logic [31:0] pat_r;            // changes every cycle so stale data never looks valid
    logic        fill_beat;        // granted fill cycle, own or snooped
    assign ds_rdata           = store[ds_addr][31:0];
    assign ds_rpar            = store[ds_addr][35:32];
    assign bus_rdata          = pat_r;
    assign shared_response_in = 1'b0;  // no other cache holds lines
    // a snooped-write fill raises no read request; the fill's tail write is skipped
    assign fill_beat = dma_grant && dma_req && !ds_we && !bus_vw_req && !snoop_supply;
    initial for (int i = 0; i < 16384; i++) store[i] = 36'h0_0000_0000;
    // grant follows request a cycle late; acks every other cycle to look slow
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_grant <= 1'b0;
            bus_ack   <= 1'b0;
            pat_r     <= 32'h0000_0000;
        end else begin
            dma_grant <= dma_req;
            bus_ack   <= !bus_ack && (bus_wt_req || (dma_grant && bus_wvalid)
                                      || bus_rd_req || fill_beat);
            pat_r     <= pat_r + 32'h1357_9BDF;
            if (ds_we) store[ds_addr] <= {ds_wpar, ds_wdata};
        end
    end
endmodule : bus_side_model

// File: testbench/snoopy_l2_cache_controller_tb.sv
`timescale 1ns/1ps
module snoopy_l2_cache_controller_tb;
    import l2c_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, cpu_req = 1'b0, cpu_we = 1'b0, snoop_valid = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, swr = 1'b0, dma_grant, bus_ack, shr_in, sup;
    logic [31:0] cpu_addr = 32'h0, snoop_addr = 32'h0, reg_wdata = 32'h0, rd, bus_rdata, ds_rdata;
    logic [7:0]  reg_addr = 8'h00;
    logic cpu_done, cpu_retry, l1_inval, dma_req, ds_we, rdq, vwq, wtq, wv, s_ack, s_resp, rtr;
    logic [13:0] ds_addr, hit_ds;
    logic [3:0]  wpar, rpar;
    logic [31:0] wdat, badr, bwd, vadr;
    int bad_count = 0, cmp_count = 0, n_we = 0, n_wv = 0, n_inv = 0, n_wt = 0, w0, v0, i0;
    localparam logic [31:0] A = 32'h0001_2344, B = 32'h0003_2348;  // same index, tags differ
    always #2.5 clk = ~clk;
    always @(posedge clk) begin  // pulse counters for line-transfer checks
        n_we  <= n_we + int'(ds_we);
        n_wv  <= n_wv + int'(wv && bus_ack);  // accepted longwords, not held cycles
        n_inv <= n_inv + int'(l1_inval);
        n_wt  <= n_wt + int'(wtq && bus_ack);
        if (vwq && wv && bus_ack) vadr <= badr;
    end
    snoopy_l2_cache_controller u_dut (.clk(clk), .rst_n(rst_n), .cpu_req(cpu_req),
        .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_done(cpu_done), .cpu_retry(cpu_retry),
        .l1_inval(l1_inval), .dma_req(dma_req), .dma_grant(dma_grant), .ds_addr(ds_addr),
        .ds_we(ds_we), .ds_wdata(wdat), .ds_wpar(wpar), .ds_rdata(ds_rdata), .ds_rpar(rpar),
        .bus_rd_req(rdq), .bus_vw_req(vwq), .bus_wt_req(wtq), .bus_addr(badr), .bus_wdata(bwd),
        .bus_wvalid(wv), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .shared_response_in(shr_in),
        .snoop_valid(snoop_valid), .snoop_wr(swr), .snoop_addr(snoop_addr),
        .snoop_ack(s_ack), .shared_response_out(s_resp), .snoop_supply(sup),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rd));
    bus_side_model u_far (.clk(clk), .rst_n(rst_n), .dma_req(dma_req), .dma_grant(dma_grant),
        .ds_addr(ds_addr), .ds_we(ds_we), .ds_wdata(wdat), .ds_wpar(wpar), .ds_rdata(ds_rdata),
        .ds_rpar(rpar), .bus_rd_req(rdq), .bus_vw_req(vwq), .bus_wt_req(wtq), .bus_wvalid(wv),
        .bus_rdata(bus_rdata), .bus_ack(bus_ack), .shared_response_in(shr_in),
        .snoop_supply(sup));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
        @(posedge clk) reg_rd <= 1'b0;
        @(negedge clk) chk(rd, exp);
    endtask : reg_read
    task automatic cpu_op(input logic [31:0] a, input logic we, output logic retry);
        @(posedge clk) begin cpu_req <= 1'b1; cpu_addr <= a; cpu_we <= we; end
        for (int k = 0; k < 300; k++) begin
            @(negedge clk);
            if (cpu_done === 1'b1 || cpu_retry === 1'b1) break;
        end
        chk(32'(cpu_done || cpu_retry), 1);
        retry  = cpu_retry;
        hit_ds = ds_addr;
        @(posedge clk) cpu_req <= 1'b0;
    endtask : cpu_op
    task automatic snoop(input logic [31:0] a, input logic wr, input logic exp);
        @(posedge clk) begin snoop_valid <= 1'b1; snoop_addr <= a; swr <= wr; end
        for (int k = 0; k < 300; k++) @(negedge clk) if (s_ack === 1'b1) break;
        chk(32'(s_ack), 1);
        @(posedge clk) snoop_valid <= 1'b0;
        @(negedge clk) chk(32'(s_resp), 32'(exp));
    endtask : snoop
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        reg_read(CSR_OFS, 32'h0000_0000);
        @(posedge clk) begin reg_wr <= 1'b1; reg_addr <= CSR_OFS; reg_wdata <= 32'h0400_0000; end
        @(posedge clk) reg_wr <= 1'b0;
        reg_read(CSR_OFS, 32'h0400_0000);
        reg_read(8'h08, 32'h0000_0000);  // unmapped place reads zero
        // io space and addresses above the cached range finish at once
        cpu_op(32'h2000_0000, 1'b0, rtr); chk(32'(rtr), 0);
        cpu_op(32'h4000_0010, 1'b0, rtr); chk(32'(rtr), 0);
        // read miss on an empty line: retry, four-beat fill, then hit
        w0 = n_we; v0 = n_wv; i0 = n_inv;
        cpu_op(A, 1'b0, rtr); chk(32'(rtr), 1);
        cpu_op(A, 1'b0, rtr); chk(32'(rtr), 0);
        chk(32'(hit_ds), 32'({A[15:4], A[3:2]}));
        chk(n_we - w0, BEATS); chk(n_inv - i0 + n_wv - v0, 0);
        // write hit dirties A; a snooped read shares it and supplies the line
        cpu_op(A, 1'b1, rtr); chk(32'(rtr), 0);
        v0 = n_wv;
        snoop(A, 1'b0, 1'b1);
        // the shared line takes a write-through before the hit completes
        cpu_op(A, 1'b1, rtr); chk(32'(rtr), 0);
        chk(n_wv - v0, BEATS);
        // conflicting miss evicts the dirty line
        w0 = n_we; v0 = n_wv; i0 = n_inv;
        cpu_op(B, 1'b0, rtr); chk(32'(rtr), 1);
        cpu_op(B, 1'b0, rtr); chk(32'(rtr), 0);
        repeat (2) @(posedge clk);
        chk(n_inv - i0, 1); chk(n_wv - v0, BEATS); chk(n_we - w0, BEATS);
        chk(vadr, {A[31:4], 4'h0});
        chk(n_wt, 1);
        // snooped write to a held line invalidates level-1 and refills it
        w0 = n_we; i0 = n_inv;
        snoop(B, 1'b0, 1'b1);
        snoop(B, 1'b1, 1'b1);
        snoop(A, 1'b0, 1'b0);
        chk(n_inv - i0, 1); chk(n_we - w0, BEATS);
        reg_read(STAT_OFS, 32'h0000_0000);
        wrap_up();
    end
endmodule : snoopy_l2_cache_controller_tb
